// >>> rtl/cpd_counter.sv
// Counter with period, two-counter frequency and encoder position modes
module cpd_counter #(
    parameter logic [15:0] TB_DIV = 16'h0001
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Encoder and measurement pins
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_z,
    input wire logic gate_in,
    input wire logic source_in,
    input wire logic sample_clk_in
);
    cpd_pkg::cpd_state_s q, n;
    cpd_pkg::cpd_edge_s ed;
    logic up;
    logic down;
    logic two;
    logic tick;
    logic gev;
    logic zhit;
    logic fire;
    logic wr;
    logic ctrl_wr;
    logic meas_end;
    logic [31:0] mw;
    logic [31:0] tgt;

    function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = strb[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    function automatic logic [31:0] ctrl_word(input cpd_pkg::cpd_state_s s);
        ctrl_word = {20'h0, s.cfg, s.state != cpd_pkg::ST_IDLE};
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= cpd_pkg::ADDR_CAP);
    endfunction

    function automatic logic [31:0] rd_word(input logic [7:0] a, input cpd_pkg::cpd_state_s s);
        rd_word = 32'h0;
        if (mapped(a)) begin
            unique case (a[4:2])
                3'h0: rd_word = ctrl_word(s);
                3'h1: rd_word = {28'h0, s.state inside {cpd_pkg::ST_MEAS, cpd_pkg::ST_GATING},
                                 s.state != cpd_pkg::ST_IDLE, s.capv, s.done};
                3'h2: rd_word = s.cnt;
                3'h3: rd_word = s.res;
                3'h4: rd_word = s.reload;
                3'h5: rd_word = s.divn;
                3'h6: rd_word = s.gticks;
                3'h7: rd_word = s.cap;
            endcase
        end
    endfunction

    // A, B, Z, gate, timebase and sample clock all cross in
    cpd_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pins({sample_clk_in, source_in, gate_in, enc_z, enc_b, enc_a}),
        .edges(ed)
    );

    cpd_quad_dec u_dec (
        .mode(q.cfg.dec),
        .two_pulse(two),
        .ed(ed),
        .up(up),
        .down(down)
    );

    assign two = q.cfg.mode == cpd_pkg::CPD_TWOP;
    assign wr = psel & penable & pwrite;
    assign ctrl_wr = wr && (paddr == cpd_pkg::ADDR_CTRL);
    assign mw = wmask(ctrl_word(q), pwdata, pstrb);
    // Internal timebase is a divided enable; external one is the chosen source edge
    assign tick = q.cfg.sext ? (q.cfg.spol ? ed.fall[cpd_pkg::IN_SRC] : ed.rise[cpd_pkg::IN_SRC])
                             : (q.tb_cnt == 16'h0);
    assign gev = q.cfg.gpol ? ed.fall[cpd_pkg::IN_GATE] : ed.rise[cpd_pkg::IN_GATE];
    // Divide-by-N of zero is treated as one
    assign tgt = (q.cfg.mode == cpd_pkg::CPD_LARGE && q.divn != 32'h0) ? q.divn : 32'h1;
    assign meas_end = gev && (q.pair + 32'h1 >= tgt);
    assign zhit = q.cfg.zen && !two && ed.lvl[cpd_pkg::IN_Z]
                  && ({ed.lvl[cpd_pkg::IN_A], ed.lvl[cpd_pkg::IN_B]} == q.cfg.zph);
    // A step in the same cycle defers the reload by one cycle
    assign fire = (q.state == cpd_pkg::ST_POS) && zhit && !q.zdone && !up && !down;

    always_comb begin
        n = q;
        n.tb_cnt = (q.tb_cnt >= TB_DIV - 16'h1) ? 16'h0 : q.tb_cnt + 16'h1;
        if (psel && !penable) begin
            n.prdata = rd_word(paddr, q);
        end
        // Register writes; flag clears come before the engine so a set wins
        if (wr) begin
            unique case (paddr)
                cpd_pkg::ADDR_STAT: begin
                    if (pstrb[0] && pwdata[cpd_pkg::STA_DONE]) begin
                        n.done = 1'b0;
                    end
                    if (pstrb[0] && pwdata[cpd_pkg::STA_CAPV]) begin
                        n.capv = 1'b0;
                    end
                end
                cpd_pkg::ADDR_RELOAD: n.reload = wmask(q.reload, pwdata, pstrb);
                cpd_pkg::ADDR_DIVN: n.divn = wmask(q.divn, pwdata, pstrb);
                cpd_pkg::ADDR_GATE: n.gticks = wmask(q.gticks, pwdata, pstrb);
                default: begin
                end
            endcase
        end
        unique case (q.state)
            cpd_pkg::ST_IDLE: begin
            end
            cpd_pkg::ST_WAIT: begin
                if (gev) begin
                    n.state = cpd_pkg::ST_MEAS;
                    n.cnt = 32'h0;
                    n.pair = 32'h0;
                end
            end
            cpd_pkg::ST_MEAS: begin
                if (tick) begin
                    n.cnt = q.cnt + 32'h1;
                end
                if (gev) begin
                    // Paired counter tallies every gate period until the divide-by-N target
                    n.pair = q.pair + 32'h1;
                end
                if (meas_end) begin
                    n.res = q.cnt + {31'h0, tick};
                    n.done = 1'b1;
                    n.state = cpd_pkg::ST_IDLE;
                end
            end
            cpd_pkg::ST_GATING: begin
                if (gev) begin
                    n.cnt = q.cnt + 32'h1;
                end
                if (tick) begin
                    // Paired counter times the known gating pulse
                    n.pair = q.pair - 32'h1;
                    if (q.pair <= 32'h1) begin
                        n.res = q.cnt + {31'h0, gev};
                        n.done = 1'b1;
                        n.state = cpd_pkg::ST_IDLE;
                    end
                end
            end
            cpd_pkg::ST_POS: begin
                if (up) begin
                    n.cnt = q.cnt + 32'h1;
                end else if (down) begin
                    n.cnt = q.cnt - 32'h1;
                end else if (fire) begin
                    n.cnt = q.reload;
                end
                // Cleared once the phase or the index is left
                n.zdone = zhit && (q.zdone || fire);
                if (ed.rise[cpd_pkg::IN_SMP]) begin
                    n.cap = q.cnt;
                    n.capv = 1'b1;
                end
            end
        endcase
        if (ctrl_wr) begin
            n.cfg = cpd_pkg::cpd_cfg_s'(mw[cpd_pkg::CTL_CFG_LSB +: cpd_pkg::CTL_CFG_W]);
            n.state = cpd_pkg::ST_IDLE;
            if (mw[cpd_pkg::CTL_ARM]) begin
                n.cnt = 32'h0;
                n.zdone = 1'b0;
                n.done = 1'b0;
                // Unknown mode codes leave the counter idle
                case (n.cfg.mode)
                    cpd_pkg::CPD_PERIOD, cpd_pkg::CPD_LARGE: n.state = cpd_pkg::ST_WAIT;
                    cpd_pkg::CPD_HIGHF: begin
                        n.state = cpd_pkg::ST_GATING;
                        n.pair = q.gticks;
                    end
                    cpd_pkg::CPD_QUAD, cpd_pkg::CPD_TWOP: n.state = cpd_pkg::ST_POS;
                    default: n.state = cpd_pkg::ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= cpd_pkg::CPD_STATE_RST;
        end else begin
            q <= n;
        end
    end

    assign prdata = q.prdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped(paddr);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_zfire;
        fire && !ctrl_wr;
    endsequence

    sequence s_pos_step;
        q.state == cpd_pkg::ST_POS && !two && !ctrl_wr;
    endsequence

    a_unarmed_hold: assert property ((q.state == cpd_pkg::ST_IDLE && !ctrl_wr)
        |=> $stable(q.cnt))
        else $error("count moved while not armed");

    a_pos_up_step: assert property (s_pos_step and (up && !down)
        |=> q.cnt == $past(q.cnt) + 32'h1)
        else $error("position count did not step up");

    a_single_edge_a: assert property ((q.state == cpd_pkg::ST_POS && !two
        && q.cfg.dec == cpd_pkg::SINGLE_EDGE_DECODE && (up || down))
        |-> (up ? ed.rise[cpd_pkg::IN_A] : ed.fall[cpd_pkg::IN_A]))
        else $error("single edge step on wrong channel A edge");

    a_double_edge_a: assert property ((q.state == cpd_pkg::ST_POS && !two
        && q.cfg.dec == cpd_pkg::DOUBLE_EDGE_DECODE && ed.fall[cpd_pkg::IN_A]
        && !ed.rise[cpd_pkg::IN_B] && !ed.fall[cpd_pkg::IN_B]) |-> (up != down))
        else $error("double edge missed an A falling edge");

    a_quad_edge_b: assert property ((q.state == cpd_pkg::ST_POS && !two
        && q.cfg.dec == cpd_pkg::QUAD_EDGE_DECODE && ed.rise[cpd_pkg::IN_B]
        && !ed.rise[cpd_pkg::IN_A] && !ed.fall[cpd_pkg::IN_A]) |-> (up != down))
        else $error("quad edge missed a B edge");

    a_two_pulse_dn: assert property ((q.state == cpd_pkg::ST_POS && two && !ctrl_wr
        && ed.rise[cpd_pkg::IN_B] && !ed.rise[cpd_pkg::IN_A])
        |=> q.cnt == $past(q.cnt) - 32'h1)
        else $error("two pulse B edge did not decrement");

    a_reload_value: assert property (s_zfire |=> q.cnt == $past(q.reload))
        else $error("index reload value not loaded");

    a_reload_once: assert property (s_zfire |=> !fire)
        else $error("index reload repeated in same phase entry");

    a_reload_soon: assert property ((q.state == cpd_pkg::ST_POS && zhit && !q.zdone
        && !ctrl_wr) |-> ##[0:1] (fire || !zhit || q.state != cpd_pkg::ST_POS))
        else $error("index reload late");

    a_period_result: assert property ((q.state == cpd_pkg::ST_MEAS && meas_end
        && !ctrl_wr) |=> q.done && q.res == $past(q.cnt) + {31'h0, $past(tick)})
        else $error("period result does not match timebase count");

    a_large_span: assert property ((q.state == cpd_pkg::ST_MEAS && gev && !meas_end
        && !ctrl_wr) |=> q.state == cpd_pkg::ST_MEAS && q.pair == $past(q.pair) + 32'h1)
        else $error("large range window ended before N periods");

    a_hf_gating: assert property ((q.state == cpd_pkg::ST_GATING && tick
        && q.pair > 32'h1 && !ctrl_wr) |=> q.state == cpd_pkg::ST_GATING ##0 !q.done)
        else $error("gating pulse ended early");
endmodule

// >>> rtl/cpd_pkg.sv
// Shared constants, types and register map of the counter period/position decoder
package cpd_pkg;
    localparam int CPD_W = 32;
    localparam int CPD_NIN = 6;

    // Input pin indices into the synchroniser
    localparam int IN_A = 0;
    localparam int IN_B = 1;
    localparam int IN_Z = 2;
    localparam int IN_GATE = 3;
    localparam int IN_SRC = 4;
    localparam int IN_SMP = 5;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_RES = 8'h0c;
    localparam logic [7:0] ADDR_RELOAD = 8'h10;
    localparam logic [7:0] ADDR_DIVN = 8'h14;
    localparam logic [7:0] ADDR_GATE = 8'h18;
    localparam logic [7:0] ADDR_CAP = 8'h1c;

    // Field positions
    localparam int CTL_ARM = 0;
    localparam int CTL_CFG_LSB = 1;
    localparam int CTL_CFG_W = 11;
    localparam int STA_DONE = 0;
    localparam int STA_CAPV = 1;

    // Reset values
    localparam logic [CPD_W-1:0] CPD_DIVN_RST = 32'h0000_0001;
    localparam logic [CPD_W-1:0] CPD_GATE_RST = 32'h0000_0100;

    typedef enum logic [2:0] {
        CPD_PERIOD = 3'h0,
        CPD_LARGE = 3'h1,
        CPD_HIGHF = 3'h2,
        CPD_QUAD = 3'h3,
        CPD_TWOP = 3'h4
    } cpd_mode_e;

    typedef enum logic [1:0] {
        SINGLE_EDGE_DECODE = 2'h0,
        DOUBLE_EDGE_DECODE = 2'h1,
        QUAD_EDGE_DECODE = 2'h2
    } cpd_dec_e;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_WAIT = 5'h02,
        ST_MEAS = 5'h04,
        ST_GATING = 5'h08,
        ST_POS = 5'h10
    } cpd_st_e;

    // Packs into CTRL bits 11:1, mode lowest
    typedef struct packed {
        logic zen;
        logic [1:0] zph;
        logic sext;
        logic spol;
        logic gpol;
        cpd_dec_e dec;
        cpd_mode_e mode;
    } cpd_cfg_s;

    typedef struct packed {
        logic [CPD_NIN-1:0] lvl;
        logic [CPD_NIN-1:0] rise;
        logic [CPD_NIN-1:0] fall;
    } cpd_edge_s;

    typedef struct packed {
        logic [CPD_NIN-1:0] s1;
        logic [CPD_NIN-1:0] s2;
        logic [CPD_NIN-1:0] s3;
        logic [CPD_NIN-1:0] lvl;
        logic [CPD_NIN-1:0] prev;
    } cpd_sync_s;

    typedef struct packed {
        cpd_st_e state;
        cpd_cfg_s cfg;
        logic done;
        logic capv;
        logic zdone;
        logic [15:0] tb_cnt;
        logic [CPD_W-1:0] cnt;
        logic [CPD_W-1:0] pair;
        logic [CPD_W-1:0] res;
        logic [CPD_W-1:0] cap;
        logic [CPD_W-1:0] reload;
        logic [CPD_W-1:0] divn;
        logic [CPD_W-1:0] gticks;
        logic [CPD_W-1:0] prdata;
    } cpd_state_s;

    localparam cpd_cfg_s CPD_CFG_RST = '{mode: CPD_PERIOD, dec: SINGLE_EDGE_DECODE, default: '0};
    localparam cpd_state_s CPD_STATE_RST = '{state: ST_IDLE, cfg: CPD_CFG_RST,
        divn: CPD_DIVN_RST, gticks: CPD_GATE_RST, default: '0};
endpackage

// >>> rtl/cpd_quad_dec.sv
// Quadrature and two-pulse direction decoder, purely combinational
module cpd_quad_dec (
    // Configuration
    input cpd_pkg::cpd_dec_e mode,
    input wire logic two_pulse,
    // Clean encoder levels and edges
    input cpd_pkg::cpd_edge_s ed,
    // Count steps
    output logic up,
    output logic down
);
    logic a;
    logic b;
    logic ae;
    logic be;

    always_comb begin
        a = ed.lvl[cpd_pkg::IN_A];
        b = ed.lvl[cpd_pkg::IN_B];
        ae = ed.rise[cpd_pkg::IN_A] | ed.fall[cpd_pkg::IN_A];
        be = ed.rise[cpd_pkg::IN_B] | ed.fall[cpd_pkg::IN_B];
        up = 1'b0;
        down = 1'b0;
        if (two_pulse) begin
            // Coincident pulses cancel out
            up = ed.rise[cpd_pkg::IN_A] & ~ed.rise[cpd_pkg::IN_B];
            down = ed.rise[cpd_pkg::IN_B] & ~ed.rise[cpd_pkg::IN_A];
        end else if (!(ae && be)) begin
            // Both channels moving at once is a glitch, not a step
            unique case (mode)
                cpd_pkg::SINGLE_EDGE_DECODE: begin
                    up = ed.rise[cpd_pkg::IN_A] & ~b;
                    down = ed.fall[cpd_pkg::IN_A] & ~b;
                end
                cpd_pkg::DOUBLE_EDGE_DECODE: begin
                    up = ae & (a != b);
                    down = ae & (a == b);
                end
                cpd_pkg::QUAD_EDGE_DECODE: begin
                    up = (ae & (a != b)) | (be & (a == b));
                    down = (ae & (a == b)) | (be & (a != b));
                end
                default: begin
                    up = 1'b0;
                    down = 1'b0;
                end
            endcase
        end
    end
endmodule

// >>> rtl/cpd_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
module cpd_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Raw pins and clean result
    input wire logic [cpd_pkg::CPD_NIN-1:0] pins,
    output cpd_pkg::cpd_edge_s edges
);
    cpd_pkg::cpd_sync_s q, n;

    always_comb begin
        n = q;
        n.s1 = pins;
        n.s2 = q.s1;
        n.s3 = q.s2;
        // Level moves only where stages two and three agree
        n.lvl = (~(q.s2 ^ q.s3) & q.s2) | ((q.s2 ^ q.s3) & q.lvl);
        n.prev = q.lvl;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Edges from registered levels only
    assign edges = '{lvl: q.lvl, rise: q.lvl & ~q.prev, fall: ~q.lvl & q.prev};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_sync_agree: assert property (!$stable(q.lvl) |-> $past(q.s2) == $past(q.s3))
        else $error("synchronised level moved without stage agreement");
endmodule

// >>> testbench/cpd_enc_model.sv
// Encoder and signal source model driving the counter pins
module cpd_enc_model (
    // Clock
    input wire logic pclk,
    // Encoder and measurement pins
    output logic enc_a,
    output logic enc_b,
    output logic enc_z,
    output logic gate_in,
    output logic source_in,
    output logic sample_clk_in
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {enc_a, enc_b, enc_z, gate_in, source_in, sample_clk_in} = 6'h00;
    end

    // Hold each level 8 clocks; the pin filter needs 4 and the count 1 more
    task automatic pin(input int idx, input logic v);
        @(posedge pclk);
        case (idx)
            cpd_pkg::IN_A: enc_a <= v;
            cpd_pkg::IN_B: enc_b <= v;
            cpd_pkg::IN_Z: enc_z <= v;
            cpd_pkg::IN_GATE: gate_in <= v;
            cpd_pkg::IN_SRC: source_in <= v;
            default: sample_clk_in <= v;
        endcase
        repeat (8) @(posedge pclk);
    endtask

    task automatic pulse(input int idx);
        pin(idx, 1'b1);
        pin(idx, 1'b0);
    endtask

    // One full cycle from A=B=0; dir 1 has A leading
    task automatic quad_cycle(input logic dir);
        for (int k = 0; k < 4; k++) begin
            pin(((k % 2 == 0) == dir) ? cpd_pkg::IN_A : cpd_pkg::IN_B, logic'(k < 2));
        end
    endtask

    // Caller raises index before entering the reload phase and keeps it there
    task automatic index(input logic v);
        pin(cpd_pkg::IN_Z, v);
    endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench of the counter period/position decoder
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] dec;
        logic dir;
        logic [31:0] exp;
    } cpd_row_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic enc_a, enc_b, enc_z, gate_in, source_in, sample_clk_in, err;
    int err_count = 0;
    int n_checks = 0;
    cpd_row_s rows[6] = '{'{3'h3, 2'h0, 1'b1, 32'h1}, '{3'h3, 2'h0, 1'b0, 32'hffffffff},
        '{3'h3, 2'h1, 1'b1, 32'h2}, '{3'h3, 2'h1, 1'b0, 32'hfffffffe},
        '{3'h3, 2'h2, 1'b1, 32'h4}, '{3'h3, 2'h2, 1'b0, 32'hfffffffc}};

    cpd_counter #(.TB_DIV(16'h0001)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
        .enc_z(enc_z), .gate_in(gate_in), .source_in(source_in),
        .sample_clk_in(sample_clk_in));
    cpd_enc_model enc (.pclk(pclk), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z),
        .gate_in(gate_in), .source_in(source_in), .sample_clk_in(sample_clk_in));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Wait on pready rather than assume zero-wait answers
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 50) begin
            err_count++;
            print_verdict();
        end
    endtask

    function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] dc,
                                        input logic gp, input logic ext, input logic zen);
        // Gate and source polarity move together so falling source edges get exercised
        return {20'h0, zen, 2'h0, ext, gp, gp, dc, m, 1'b1};
    endfunction

    task automatic wait_done();
        int i;
        i = 0;
        do begin
            apb(1'b0, cpd_pkg::ADDR_STAT, 32'h0);
            i++;
        end while (rd[cpd_pkg::STA_DONE] !== 1'b1 && i < 40);
        if (i >= 40) begin
            err_count++;
            print_verdict();
        end
    endtask

    // n gate periods with k source edges in each
    task automatic meas(input logic [31:0] c, input int n, input int k);
        apb(1'b1, cpd_pkg::ADDR_CTRL, c);
        for (int i = 0; i <= n; i++) begin
            enc.pulse(cpd_pkg::IN_GATE);
            if (i < n) repeat (k) enc.pulse(cpd_pkg::IN_SRC);
        end
        wait_done();
        apb(1'b0, cpd_pkg::ADDR_RES, 32'h0);
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        err_count++;
        print_verdict();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[r]) begin
            apb(1'b1, cpd_pkg::ADDR_CTRL, ctl(rows[r].mode, rows[r].dec, 1'b0, 1'b0, 1'b0));
            enc.quad_cycle(rows[r].dir);
            apb(1'b0, cpd_pkg::ADDR_COUNT, 32'h0);
            `CHK(rd, rows[r].exp)
            $display("decode row %0d done", r);
        end
        // Hand-written cases
        apb(1'b0, cpd_pkg::ADDR_DIVN, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b0, cpd_pkg::ADDR_GATE, 32'h0);
        `CHK(rd, 32'h100)
        apb(1'b0, 8'h20, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, cpd_pkg::ADDR_RELOAD, 32'hffffffff);
        apb(1'b0, cpd_pkg::ADDR_RELOAD, 32'h0);
        `CHK(rd, 32'hffffffff)
        $display("register test done");
        apb(1'b1, cpd_pkg::ADDR_CTRL, ctl(3'h3, 2'h2, 1'b0, 1'b0, 1'b0) & 32'hfffffffe);
        enc.quad_cycle(1'b1);
        apb(1'b0, cpd_pkg::ADDR_COUNT, 32'h0);
        // Disarming keeps the count left by the last decode row
        `CHK(rd, rows[5].exp)
        apb(1'b1, cpd_pkg::ADDR_CTRL, ctl(3'h4, 2'h0, 1'b0, 1'b0, 1'b0));
        repeat (3) enc.pulse(cpd_pkg::IN_A);
        enc.pulse(cpd_pkg::IN_B);
        apb(1'b0, cpd_pkg::ADDR_COUNT, 32'h0);
        `CHK(rd, 32'h2)
        $display("arm and two-pulse tests done");
        for (int g = 0; g < 2; g++) begin
            meas(ctl(3'h0, 2'h0, g[0], 1'b1, 1'b0), 1, 5);
            `CHK(rd, 32'h5)
        end
        apb(1'b1, cpd_pkg::ADDR_DIVN, 32'h3);
        meas(ctl(3'h1, 2'h0, 1'b0, 1'b1, 1'b0), 3, 2);
        `CHK(rd, 32'h6)
        apb(1'b1, cpd_pkg::ADDR_GATE, 32'h14);
        meas(ctl(3'h2, 2'h0, 1'b0, 1'b0, 1'b0), 0, 0);
        // The single gate edge falls inside the 20-tick gating pulse
        `CHK(rd, 32'h1)
        $display("measurement tests done");
        apb(1'b1, cpd_pkg::ADDR_RELOAD, 32'h55);
        apb(1'b1, cpd_pkg::ADDR_CTRL, ctl(3'h3, 2'h2, 1'b0, 1'b0, 1'b1));
        enc.pin(cpd_pkg::IN_A, 1'b1);
        enc.pin(cpd_pkg::IN_B, 1'b1);
        enc.pin(cpd_pkg::IN_A, 1'b0);
        enc.index(1'b1);
        enc.pin(cpd_pkg::IN_B, 1'b0);
        apb(1'b0, cpd_pkg::ADDR_COUNT, 32'h0);
        `CHK(rd, 32'h55)
        // A new reload value while still in phase must not be applied again
        apb(1'b1, cpd_pkg::ADDR_RELOAD, 32'haa);
        apb(1'b0, cpd_pkg::ADDR_COUNT, 32'h0);
        `CHK(rd, 32'h55)
        enc.pin(cpd_pkg::IN_A, 1'b1);
        enc.index(1'b0);
        apb(1'b0, cpd_pkg::ADDR_COUNT, 32'h0);
        `CHK(rd, 32'h56)
        enc.pulse(cpd_pkg::IN_SMP);
        apb(1'b0, cpd_pkg::ADDR_CAP, 32'h0);
        `CHK(rd, 32'h56)
        apb(1'b0, cpd_pkg::ADDR_STAT, 32'h0);
        `CHK(rd[cpd_pkg::STA_CAPV], 1'b1)
        apb(1'b1, cpd_pkg::ADDR_STAT, 32'h3);
        apb(1'b0, cpd_pkg::ADDR_STAT, 32'h0);
        `CHK(rd[cpd_pkg::STA_CAPV], 1'b0)
        $display("index and capture tests done");
        print_verdict();
    end
endmodule
